// file: jpol_pkg.sv
// Constants, register map and types of the jog pulse output block
// Summary of operation
// - Forward start: jog fwd on, limits on, rev off
// - Pulse-direction forward: pulse toggles, direction high
// - Train mode forward: forward train toggles, reverse low
// - Position counts up per forward pulse
// - Jog release stops pulses, direction stays
// - Stopped: position holds, no more counting
// - Forward limit off halts motion as abnormal stop
// - Limit stop sets abnormal end flag
// - Reverse jog mirrors forward, position counts down
`default_nettype none
package jpol_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned POS_W  = 32;

	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_POS_LOW   = 8'h08;
	localparam logic [7:0] REG_POS_HIGH  = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
	localparam logic [7:0] REG_IRQ_EN    = 8'h18;

	localparam int unsigned CTRL_MODE_BIT  = 0;
	localparam int unsigned CTRL_ABCLR_BIT = 1;
	localparam int unsigned ST_FWD_BIT     = 0;
	localparam int unsigned ST_REV_BIT     = 1;
	localparam int unsigned ST_ABN_BIT     = 2;
	localparam int unsigned ST_DIR_BIT     = 3;
	localparam int unsigned EV_LIMIT_BIT   = 0;
	localparam int unsigned EV_DONE_BIT    = 1;
	localparam int unsigned EV_W           = 2;

	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PULSE_HALF_NS = 5000;
	localparam int unsigned PULSE_HALF_CYC =
		(PULSE_HALF_NS / CLK_PERIOD_NS) > 0 ? (PULSE_HALF_NS / CLK_PERIOD_NS) : 1;

	localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		JPOL_IDLE = 2'b00,
		JPOL_FWD  = 2'b01,
		JPOL_REV  = 2'b10
	} jpol_state_e;

	typedef enum logic {
		JPOL_MODE_PULSE_DIR = 1'b0,
		JPOL_MODE_TRAINS    = 1'b1
	} jpol_mode_e;

	typedef struct packed {
		logic fwd_limit;
		logic rev_limit;
		logic jog_fwd;
		logic jog_rev;
	} jpol_pins_s;
endpackage
`default_nettype wire

// file: jpol_pulse_gen.sv
// Square-wave pulse source with a rising-edge strobe
`timescale 1ns/10ps
`default_nettype none
module jpol_pulse_gen #(
	parameter int unsigned HALF_CYC = jpol_pkg::PULSE_HALF_CYC
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic run_in,
	output logic      phase_out,
	output logic      rise_out
);
	import jpol_pkg::*;
	localparam int unsigned CNT_W = $clog2(HALF_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             phase_q;
	logic             phase_d;
	logic             rise_q;
	logic             rise_d;

	always_comb begin
		cnt_d   = cnt_q;
		phase_d = phase_q;
		rise_d  = 1'b0;
		// Stopping parks the wave low so a new run starts from a clean phase
		if (!run_in) begin
			cnt_d   = '0;
			phase_d = 1'b0;
		end else if (cnt_q == CNT_LAST) begin
			cnt_d   = '0;
			phase_d = !phase_q;
			rise_d  = !phase_q;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cnt_q   <= '0;
			phase_q <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			phase_q <= phase_d;
			rise_q  <= rise_d;
		end
	end

	assign phase_out = phase_q;
	assign rise_out  = rise_q;
endmodule
`default_nettype wire

// file: jpol_top.sv
// Jog pulse output with limit switches, position counter and register port
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module jpol_top #(
	parameter int unsigned HALF_CYC = jpol_pkg::PULSE_HALF_CYC
) (
	input  wire logic                         mclk_in,
	input  wire logic                         rst_in,
	input  wire logic                         fwd_limit_in,
	input  wire logic                         rev_limit_in,
	input  wire logic                         jog_fwd_in,
	input  wire logic                         jog_rev_in,
	input  wire logic [jpol_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [jpol_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                         wr_in,
	input  wire logic                         rd_in,
	output logic      [jpol_pkg::DATA_W-1:0] rdata_out,
	output logic                              pulse_out,
	output logic                              direction_out,
	output logic                              fwd_pulse_out,
	output logic                              rev_pulse_out,
	output logic                              abnormal_end_flag_out,
	output logic                              irq_out
);
	import jpol_pkg::*;

	jpol_pins_s       meta_q;
	jpol_pins_s       pins_q;
	jpol_pins_s       raw;

	jpol_state_e      state_q;
	jpol_state_e      state_d;
	logic [POS_W-1:0] pos_q;
	logic [POS_W-1:0] pos_d;
	logic             dir_q;
	logic             dir_d;
	logic             abn_q;
	logic             abn_d;
	logic             limit_stop;
	logic             done_stop;
	logic             start;

	jpol_mode_e       mode_q;
	jpol_mode_e       mode_d;
	logic [EV_W-1:0]  irq_stat_q;
	logic [EV_W-1:0]  irq_stat_d;
	logic [EV_W-1:0]  irq_en_q;
	logic [EV_W-1:0]  irq_en_d;
	logic [EV_W-1:0]  events;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic             irq_q;
	logic             irq_d;

	logic             pulse_q;
	logic             pulse_d;
	logic             fwdp_q;
	logic             fwdp_d;
	logic             revp_q;
	logic             revp_d;
	logic             moving;
	logic             gen_phase;
	logic             gen_rise;

	// Two-stage synchronisers on the switch pins; only pins_q feeds logic
	assign raw = '{fwd_limit: fwd_limit_in, rev_limit: rev_limit_in,
		jog_fwd: jog_fwd_in, jog_rev: jog_rev_in};

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			meta_q <= '0;
			pins_q <= '0;
		end else begin
			meta_q <= raw;
			pins_q <= meta_q;
		end
	end

	assign moving = (state_q != JPOL_IDLE);

	jpol_pulse_gen #(
		.HALF_CYC (HALF_CYC)
	) u_gen (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.run_in    (moving),
		.phase_out (gen_phase),
		.rise_out  (gen_rise)
	);

	// Motion sequencer
	always_comb begin
		state_d    = state_q;
		pos_d      = pos_q;
		dir_d      = dir_q;
		abn_d      = abn_q;
		limit_stop = 1'b0;
		done_stop  = 1'b0;
		start      = 1'b0;
		unique case (state_q)
			JPOL_IDLE: begin
				// Limits are closed contacts: a low level means a tripped limit
				if (pins_q.fwd_limit && pins_q.rev_limit) begin
					if (pins_q.jog_fwd && !pins_q.jog_rev) begin
						state_d = JPOL_FWD;
						dir_d   = 1'b1;
						start   = 1'b1;
					end else if (pins_q.jog_rev && !pins_q.jog_fwd) begin
						state_d = JPOL_REV;
						dir_d   = 1'b0;
						start   = 1'b1;
					end
				end
			end
			JPOL_FWD: begin
				if (gen_rise) begin
					pos_d = pos_q + 1'b1;
				end
				if (!pins_q.fwd_limit) begin
					state_d    = JPOL_IDLE;
					limit_stop = 1'b1;
				end else if (!pins_q.jog_fwd || pins_q.jog_rev) begin
					state_d   = JPOL_IDLE;
					done_stop = 1'b1;
				end
			end
			JPOL_REV: begin
				if (gen_rise) begin
					pos_d = pos_q - 1'b1;
				end
				if (!pins_q.rev_limit) begin
					state_d    = JPOL_IDLE;
					limit_stop = 1'b1;
				end else if (!pins_q.jog_rev || pins_q.jog_fwd) begin
					state_d   = JPOL_IDLE;
					done_stop = 1'b1;
				end
			end
			default: begin
				state_d = JPOL_IDLE;
			end
		endcase
		// A new motion clears the flag; a limit stop sets it and wins over software
		if (start || (wr_in && addr_in == REG_CTRL && wdata_in[CTRL_ABCLR_BIT])) begin
			abn_d = 1'b0;
		end
		if (limit_stop) begin
			abn_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q <= JPOL_IDLE;
			pos_q   <= POS_RESET;
			dir_q   <= 1'b0;
			abn_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			pos_q   <= pos_d;
			dir_q   <= dir_d;
			abn_q   <= abn_d;
		end
	end

	// Pin drivers; direction only follows a start, so it holds after a stop
	always_comb begin
		pulse_d = 1'b0;
		fwdp_d  = 1'b0;
		revp_d  = 1'b0;
		if (mode_q == JPOL_MODE_PULSE_DIR) begin
			pulse_d = moving && gen_phase;
		end else begin
			fwdp_d = (state_q == JPOL_FWD) && gen_phase;
			revp_d = (state_q == JPOL_REV) && gen_phase;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			pulse_q <= 1'b0;
			fwdp_q  <= 1'b0;
			revp_q  <= 1'b0;
		end else begin
			pulse_q <= pulse_d;
			fwdp_q  <= fwdp_d;
			revp_q  <= revp_d;
		end
	end

	// Register port and interrupt
	assign events = {done_stop, limit_stop};

	always_comb begin
		mode_d     = mode_q;
		irq_en_d   = irq_en_q;
		irq_stat_d = irq_stat_q;
		rdata_d    = '0;
		if (wr_in) begin
			unique case (addr_in)
				REG_CTRL:      mode_d = jpol_mode_e'(wdata_in[CTRL_MODE_BIT]);
				REG_IRQ_EN:    irq_en_d = wdata_in[EV_W-1:0];
				REG_IRQ_CLEAR: irq_stat_d = irq_stat_q & ~wdata_in[EV_W-1:0];
				default:       ;
			endcase
		end
		// Set after clear so an event in the clearing cycle survives
		irq_stat_d = irq_stat_d | events;
		if (rd_in) begin
			unique case (addr_in)
				REG_CTRL:     rdata_d[CTRL_MODE_BIT] = mode_q;
				REG_STATUS: begin
					rdata_d[ST_FWD_BIT] = (state_q == JPOL_FWD);
					rdata_d[ST_REV_BIT] = (state_q == JPOL_REV);
					rdata_d[ST_ABN_BIT] = abn_q;
					rdata_d[ST_DIR_BIT] = dir_q;
				end
				REG_POS_LOW:  rdata_d[WORD_W-1:0] = pos_q[WORD_W-1:0];
				REG_POS_HIGH: rdata_d[WORD_W-1:0] = pos_q[POS_W-1:WORD_W];
				REG_IRQ_STAT: rdata_d[EV_W-1:0] = irq_stat_q;
				REG_IRQ_EN:   rdata_d[EV_W-1:0] = irq_en_q;
				default:      rdata_d = '0;
			endcase
		end
		irq_d = |(irq_stat_d & irq_en_d);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mode_q     <= JPOL_MODE_PULSE_DIR;
			irq_en_q   <= '0;
			irq_stat_q <= '0;
			rdata_q    <= '0;
			irq_q      <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			irq_en_q   <= irq_en_d;
			irq_stat_q <= irq_stat_d;
			rdata_q    <= rdata_d;
			irq_q      <= irq_d;
		end
	end

	assign rdata_out             = rdata_q;
	assign pulse_out             = pulse_q;
	assign direction_out         = dir_q;
	assign fwd_pulse_out         = fwdp_q;
	assign rev_pulse_out         = revp_q;
	assign abnormal_end_flag_out = abn_q;
	assign irq_out               = irq_q;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	chk_fwd_start:
	assert property (state_q == JPOL_IDLE && pins_q.jog_fwd && !pins_q.jog_rev
		&& pins_q.fwd_limit && pins_q.rev_limit |=> state_q == JPOL_FWD ##1 dir_q)
		else $error("forward start not taken");

	chk_pd_fwd_out:
	assert property (state_q == JPOL_FWD && mode_q == JPOL_MODE_PULSE_DIR
		&& gen_phase |=> pulse_q && direction_out)
		else $error("pulse or direction wrong in forward motion");

	chk_train_fwd:
	assert property (state_q == JPOL_FWD && mode_q == JPOL_MODE_TRAINS
		|=> !revp_q && !pulse_q && fwdp_q == $past(gen_phase))
		else $error("train outputs wrong in forward motion");

	chk_pos_up:
	assert property (state_q == JPOL_FWD && gen_rise |=> pos_q == $past(pos_q) + 1'b1)
		else $error("position did not count up");

	chk_release_stop:
	assert property (state_q == JPOL_FWD && pins_q.fwd_limit && !pins_q.jog_fwd
		|=> state_q == JPOL_IDLE && dir_q ##1 !pulse_q && !fwdp_q && dir_q)
		else $error("release did not stop cleanly");

	chk_pos_hold:
	assert property (state_q == JPOL_IDLE |=> $stable(pos_q))
		else $error("position moved while stopped");

	chk_limit_stop:
	assert property (state_q == JPOL_FWD && !pins_q.fwd_limit
		|=> state_q == JPOL_IDLE ##1 !pulse_q && !fwdp_q && $stable(pos_q))
		else $error("forward limit did not halt motion");

	chk_abn_flag:
	assert property (moving && state_d == JPOL_IDLE && limit_stop
		|=> abnormal_end_flag_out && irq_stat_q[EV_LIMIT_BIT])
		else $error("abnormal end not flagged");

	chk_pos_down:
	assert property (state_q == JPOL_REV && gen_rise |=> pos_q == $past(pos_q) - 1'b1)
		else $error("position did not count down");

	chk_both_jog:
	assert property (state_q == JPOL_IDLE && pins_q.jog_fwd && pins_q.jog_rev
		|=> state_q == JPOL_IDLE ##1 !pulse_q && !fwdp_q && !revp_q)
		else $error("motion started with both jog inputs on");
endmodule
`default_nettype wire

// file: jpol_drive_model.sv
// Behavioural servo drive that counts the pulse trains it receives
`timescale 1ns/10ps
`default_nettype none
module jpol_drive_model (
	input  wire logic        mclk_in,
	input  wire logic        pulse_in,
	input  wire logic        dir_in,
	input  wire logic        fwd_in,
	input  wire logic        rev_in,
	output var logic  [31:0] pos_out,
	output var int unsigned  n_pd_out,
	output var int unsigned  n_fp_out,
	output var int unsigned  n_rp_out
);
	logic pulse_q;
	logic fwd_q;
	logic rev_q;

	initial begin
		pulse_q = 1'b0;
		fwd_q = 1'b0;
		rev_q = 1'b0;
		pos_out = 32'h0000_0000;
		n_pd_out = 0;
		n_fp_out = 0;
		n_rp_out = 0;
	end

	// Only one pin is expected to carry a train at a time
	always @(posedge mclk_in) begin
		pulse_q <= pulse_in;
		fwd_q <= fwd_in;
		rev_q <= rev_in;
		if (pulse_in && !pulse_q) begin
			n_pd_out <= n_pd_out + 1;
			pos_out <= dir_in ? pos_out + 32'h1 : pos_out - 32'h1;
		end
		if (fwd_in && !fwd_q) begin
			n_fp_out <= n_fp_out + 1;
			pos_out <= pos_out + 32'h1;
		end
		if (rev_in && !rev_q) begin
			n_rp_out <= n_rp_out + 1;
			pos_out <= pos_out - 32'h1;
		end
	end
endmodule
`default_nettype wire

// file: jog_pulse_output_with_limits_tb_top.sv
// Self-checking bench for the jog pulse output block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
	$display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module jog_pulse_output_with_limits_tb_top;
	import jpol_pkg::*;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] mask;
	} jpol_note_s;

	logic        mclk_in, rst_in, fwd_limit_in, rev_limit_in, jog_fwd_in, jog_rev_in;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, rdata_out, pos;
	logic        wr_in, rd_in, rd_q, irq_on;
	logic        pulse_out, direction_out, fwd_pulse_out, rev_pulse_out;
	logic        abnormal_end_flag_out, irq_out;
	int unsigned n_pd, n_fp, n_rp, seed_v;
	int          error_cnt = 0;
	int          tests_run = 0;
	jpol_note_s  notes[$];
	jpol_note_s  n;

	jpol_top #(.HALF_CYC(2)) jpol_top_inst (
		.mclk_in(mclk_in), .rst_in(rst_in), .fwd_limit_in(fwd_limit_in),
		.rev_limit_in(rev_limit_in), .jog_fwd_in(jog_fwd_in), .jog_rev_in(jog_rev_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .pulse_out(pulse_out), .direction_out(direction_out),
		.fwd_pulse_out(fwd_pulse_out), .rev_pulse_out(rev_pulse_out),
		.abnormal_end_flag_out(abnormal_end_flag_out), .irq_out(irq_out));

	jpol_drive_model jpol_drive_model_inst (
		.mclk_in(mclk_in), .pulse_in(pulse_out), .dir_in(direction_out),
		.fwd_in(fwd_pulse_out), .rev_in(rev_pulse_out), .pos_out(pos),
		.n_pd_out(n_pd), .n_fp_out(n_fp), .n_rp_out(n_rp));

	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		notes.push_back('{exp: e & m, mask: m});
		@(posedge mclk_in);
		rd_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk_in) begin
		if (rd_q) begin
			n = notes.pop_front();
			`CHK(rdata_out & n.mask, n.exp)
		end
		rd_q <= rd_in;
	end

	task automatic run(input logic fwd, input logic mode, input logic trip);
		int unsigned pd0, fp0, rp0;
		pd0 = n_pd;
		fp0 = n_fp;
		rp0 = n_rp;
		// Unused control bits are random; a stray flag clear before a start is harmless
		wr(REG_CTRL, ($urandom() & 32'hFFFF_FFFE) | {31'h0, mode});
		rd(REG_CTRL, {31'h0, mode}, 32'hFFFF_FFFF);
		@(posedge mclk_in);
		jog_fwd_in <= fwd;
		jog_rev_in <= !fwd;
		repeat ($urandom_range(60, 30)) @(posedge mclk_in);
		rd(REG_STATUS, fwd ? 32'h1 : 32'h2, 32'h3);
		if (trip) begin
			fwd_limit_in <= !fwd;
			rev_limit_in <= fwd;
		end else begin
			jog_fwd_in <= 1'b0;
			jog_rev_in <= 1'b0;
		end
		repeat (10) @(posedge mclk_in);
		#1;
		`CHK(pulse_out | fwd_pulse_out | rev_pulse_out, 1'b0)
		`CHK(n_pd > pd0, mode == JPOL_MODE_PULSE_DIR)
		`CHK(n_fp > fp0, mode == JPOL_MODE_TRAINS && fwd)
		`CHK(n_rp > rp0, mode == JPOL_MODE_TRAINS && !fwd)
		if (mode == JPOL_MODE_PULSE_DIR) begin
			`CHK(direction_out, fwd)
		end
		`CHK(abnormal_end_flag_out, trip)
		`CHK(irq_out, irq_on)
		rd(REG_STATUS, {28'h0, fwd, trip, 2'b00}, 32'h0000_000F);
		rd(REG_POS_LOW, {16'h0, pos[15:0]}, 32'hFFFF_FFFF);
		rd(REG_POS_HIGH, {16'h0, pos[31:16]}, 32'hFFFF_FFFF);
		repeat (20) @(posedge mclk_in);
		rd(REG_POS_LOW, {16'h0, pos[15:0]}, 32'hFFFF_FFFF);
		rd(REG_IRQ_STAT, trip ? 32'h1 : 32'h2, trip ? 32'h1 : 32'h2);
		wr(REG_IRQ_CLEAR, 32'h3);
		jog_fwd_in <= 1'b0;
		jog_rev_in <= 1'b0;
		@(posedge mclk_in);
		fwd_limit_in <= 1'b1;
		rev_limit_in <= 1'b1;
		repeat (5) @(posedge mclk_in);
		#1;
		`CHK(irq_out, 1'b0)
		$display("test run fwd=%0d mode=%0d trip=%0d done", fwd, mode, trip);
	endtask

	initial begin
		int unsigned s0;
		rst_in = 1'b1;
		fwd_limit_in = 1'b1;
		rev_limit_in = 1'b1;
		jog_fwd_in = 1'b0;
		jog_rev_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 32'h0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		rd_q = 1'b0;
		irq_on = 1'b0;
		seed_v = $urandom(60683);
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(REG_STATUS, 32'h0, 32'hFFFF_FFFF);
		rd(REG_POS_LOW, 32'h0, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, 32'hFFFF_FFFF);
		rd(REG_IRQ_EN, 32'h0, 32'hFFFF_FFFF);
		$display("test reset values done");
		// Interrupt masked on the first run, then enabled
		run(1'b1, 1'b0, 1'b0);
		wr(REG_IRQ_EN, 32'h3);
		irq_on = 1'b1;
		run(1'b0, 1'b0, 1'b0);
		run(1'b1, 1'b1, 1'b0);
		run(1'b0, 1'b1, 1'b0);
		run(1'b1, 1'b0, 1'b1);
		run(1'b0, 1'b1, 1'b1);
		for (int i = 0; i < 2; i++) begin
			s0 = n_pd + n_fp + n_rp;
			@(posedge mclk_in);
			jog_fwd_in <= 1'b1;
			jog_rev_in <= (i == 0);
			rev_limit_in <= (i == 0);
			repeat (40) @(posedge mclk_in);
			rd(REG_STATUS, 32'h0, 32'h3);
			`CHK(n_pd + n_fp + n_rp, s0)
			jog_fwd_in <= 1'b0;
			jog_rev_in <= 1'b0;
			@(posedge mclk_in);
			rev_limit_in <= 1'b1;
			repeat (5) @(posedge mclk_in);
			$display("test blocked start %0d done", i);
		end
		repeat (3) @(posedge mclk_in);
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
